/* File: common/vgc_cfg.svh */
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from package and design files
`ifndef VGC_CFG_SVH
`define VGC_CFG_SVH

// local processor byte addresses
`define VGC_LOC_BASE_CFG   32'hFFFE201B
`define VGC_LOC_GLOBAL1    32'hFFFE2023
`define VGC_LOC_BOARD_IDENTIFIER   32'hFFFE2025
`define VGC_LOC_SHARED0    32'hFFFE2027
`define VGC_LOC_SHARED1    32'hFFFE2029
`define VGC_LOC_SHARED2    32'hFFFE202B
`define VGC_LOC_SHARED3    32'hFFFE202D
`define VGC_LOC_SHARED4    32'hFFFE202F

// short i/o block: upper byte fixed, base nibble, register index
`define VGC_VME_HIGH_BYTE  8'h00
`define VGC_BASE_OFF       4'hF
`define VGC_IDX_GLOBAL1    3'h1
`define VGC_IDX_BOARD_IDENTIFIER   3'h2
`define VGC_IDX_SHARED0    3'h3
`define VGC_BYTE_COUNT     6

// global control/status bit positions
`define VGC_BIT_LOW        0
`define VGC_BIT_HIGH       1
`define VGC_BIT_FAIL       4
`define VGC_BIT_ISF        5
`define VGC_BIT_STRAP      6
`define VGC_BIT_RH         7

// reset values
`define VGC_RST_BOARD_IDENTIFIER   8'h00
`define VGC_RST_SHARED0    8'hFF
`define VGC_RST_SHARED     8'h00
`define VGC_RST_BASE       4'hF

// least reset-and-hold time kept by the writing master
`define VGC_CLK_PERIOD_NS  100
`define VGC_RH_MIN_NS      35000
`define VGC_RH_MIN_CYC     ((`VGC_RH_MIN_NS + `VGC_CLK_PERIOD_NS - 1) / `VGC_CLK_PERIOD_NS)

`endif

/* File: common/vgc_pkg.sv */
// types shared by the register bank modules
// assumes vgc_cfg.svh on the include path
package vgc_pkg;
  typedef logic [7:0]  vgc_byte_t;
  typedef logic [31:0] vgc_laddr_t;
  typedef logic [15:0] vgc_vaddr_t;
  typedef logic [2:0]  vgc_idx_t;
endpackage

/* File: rtl/vgc_flag_bit.sv */
// one sticky flag: set from one port, cleared by another, set wins
// assumes set and clear requests are one-cycle, synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module vgc_flag_bit (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic setReq,
  input  wire logic clrReq,
  output logic      flagQ
);
  typedef struct packed {
    logic flag;
  } vgc_flag_s;

  vgc_flag_s state_q;
  vgc_flag_s state_d;

  // set beats a clear in the same cycle
  always_comb begin
    state_d = state_q;
    if (setReq) begin
      state_d.flag = 1'b1;
    end else if (clrReq) begin
      state_d.flag = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign flagQ = state_q.flag;

  // a set is never lost, a lone clear always lands
  chk_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_n) setReq |=> flagQ)
    else $error("flag set lost");
  chk_clear_lands: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clrReq && !setReq) |=> !flagQ)
    else $error("flag clear ignored");
endmodule
`default_nettype wire

/* File: rtl/vgc_byte_reg.sv */
// one byte register with two write ports, the local port taking priority
// assumes write strobes are one-cycle, synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module vgc_byte_reg #(
  parameter vgc_pkg::vgc_byte_t RESET_VAL = 8'h00
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               locWr,
  input  wire vgc_pkg::vgc_byte_t locData,
  input  wire logic               vmeWr,
  input  wire vgc_pkg::vgc_byte_t vmeData,
  output vgc_pkg::vgc_byte_t      valueQ
);
  import vgc_pkg::*;

  typedef struct packed {
    vgc_byte_t value;
  } vgc_byte_s;

  vgc_byte_s state_q;
  vgc_byte_s state_d;

  // local write overrides a vme write of the same cycle
  always_comb begin
    state_d = state_q;
    if (locWr) begin
      state_d.value = locData;
    end else if (vmeWr) begin
      state_d.value = vmeData;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q.value <= RESET_VAL;
    end else begin
      state_q <= state_d;
    end
  end

  assign valueQ = state_q.value;

  chk_local_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
    locWr |=> valueQ == $past(locData))
    else $error("local byte write lost");
endmodule
`default_nettype wire

/* File: rtl/vgc_csr_bank.sv */
// dual-ported global control/status register bank
// assumes both access ports are synchronous to ref_clk and present
// one-cycle select pulses; vme side is already qualified as supervisor short i/o
//
// What this block does
// - Low flag bit 0: set only by vme write of 1, cleared by local 1.
// - Low flag set and enabled requests level 1 interrupt until cleared.
// - High flag bit 1: set only by vme write of 1, cleared by local 1.
// - High flag set and enabled requests level 5 interrupt until cleared.
// - Bit 4 mirrors the board-failure line, read only.
// - Bit 5 inhibit, both ports, reset 0; when 1 stop driving sysfail.
// - Inhibit never affects the board-failure status bit.
// - Bit 6 reads the system-controller strap, read only.
// - Bit 7 reset-and-hold, both ports, reset 0, holds board in reset.
// - A self-set reset-and-hold stays until another master clears it.
// - Flag functions work only while the base nibble maps the set.
// - Board identifier: local read/write, vme read only, reset 0.
// - Shared byte 0 read/write from both ports, resets to all ones.
// - Shared bytes 1-4 read/write both ports at 9,B,D,F, reset 0.
// - Vme block of 16 bytes chosen by base nibble, bits 1-3 index.
// - Base nibble resets to F, which means no vme response.
`timescale 1ns/1ps
`default_nettype none
`include "vgc_cfg.svh"
module vgc_csr_bank (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic                locSel,
  input  wire logic                locWrite,
  input  wire vgc_pkg::vgc_laddr_t locAddr,
  input  wire vgc_pkg::vgc_byte_t  locWdata,
  output vgc_pkg::vgc_byte_t       locRdata,
  output logic                     locAck,
  input  wire logic                vmeSel,
  input  wire logic                vmeWrite,
  input  wire vgc_pkg::vgc_vaddr_t vmeAddr,
  input  wire vgc_pkg::vgc_byte_t  vmeWdata,
  output vgc_pkg::vgc_byte_t       vmeRdata,
  output logic                     vmeAck,
  input  wire logic                boardFailLine,
  input  wire logic                strapSysCon,
  input  wire logic                lowIrqEnable,
  input  wire logic                highIrqEnable,
  output logic                     irqLevel1Req,
  output logic                     irqLevel5Req,
  output logic                     sysfailAssert,
  output logic                     boardResetHold,
  output logic [3:0]               baseNibble
);
  import vgc_pkg::*;

  localparam int NB = `VGC_BYTE_COUNT;

  typedef struct packed {
    logic [3:0] base;
    logic       sysfail_inhibit;
    logic       rh;
    logic       fail;
    logic       strap;
    logic       sysfail;
    logic       irq1;
    logic       irq5;
    vgc_byte_t  locRd;
    logic       locAck;
    vgc_byte_t  vmeRd;
    logic       vmeAck;
  } vgc_bank_s;

  vgc_bank_s state_q;
  vgc_bank_s state_d;

  logic      locHit;
  logic      locBaseHit;
  vgc_idx_t  locIdx;
  logic      baseValid;
  logic      vmeHit;
  vgc_idx_t  vmeIdx;
  logic      locWrG1;
  logic      vmeWrG1;
  logic      lowFlag;
  logic      highFlag;
  vgc_byte_t global1;
  vgc_byte_t bytesQ [NB];
  logic      locWrByte [NB];
  logic      vmeWrByte [NB];

  // local address decode at the fixed byte addresses
  always_comb begin
    locHit = 1'b1;
    locBaseHit = 1'b0;
    locIdx = 3'h0;
    if (locAddr == `VGC_LOC_BASE_CFG) begin
      locBaseHit = 1'b1;
    end else if (locAddr == `VGC_LOC_GLOBAL1) begin
      locIdx = `VGC_IDX_GLOBAL1;
    end else if (locAddr == `VGC_LOC_BOARD_IDENTIFIER) begin
      locIdx = `VGC_IDX_BOARD_IDENTIFIER;
    end else if (locAddr == `VGC_LOC_SHARED0) begin
      locIdx = 3'h3;
    end else if (locAddr == `VGC_LOC_SHARED1) begin
      locIdx = 3'h4;
    end else if (locAddr == `VGC_LOC_SHARED2) begin
      locIdx = 3'h5;
    end else if (locAddr == `VGC_LOC_SHARED3) begin
      locIdx = 3'h6;
    end else if (locAddr == `VGC_LOC_SHARED4) begin
      locIdx = 3'h7;
    end else begin
      locHit = 1'b0;
    end
  end

  // vme decode: odd bytes of a 16-byte block, silent while base is F
  assign baseValid = (state_q.base != `VGC_BASE_OFF);
  assign vmeIdx    = vmeAddr[3:1];
  assign vmeHit    = vmeSel && baseValid && vmeAddr[0] && (vmeIdx != 3'h0)
                   && (vmeAddr[15:8] == `VGC_VME_HIGH_BYTE)
                   && (vmeAddr[7:4] == state_q.base);

  assign locWrG1 = locSel && locWrite && !locBaseHit && locHit && (locIdx == `VGC_IDX_GLOBAL1);
  assign vmeWrG1 = vmeHit && vmeWrite && (vmeIdx == `VGC_IDX_GLOBAL1);

  // signal flags: vme sets, local clears, set wins
  vgc_flag_bit u_low_flag (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .setReq  (vmeWrG1 && vmeWdata[`VGC_BIT_LOW]),
    .clrReq  (locWrG1 && locWdata[`VGC_BIT_LOW]),
    .flagQ   (lowFlag)
  );
  vgc_flag_bit u_high_flag (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .setReq  (vmeWrG1 && vmeWdata[`VGC_BIT_HIGH]),
    .clrReq  (locWrG1 && locWdata[`VGC_BIT_HIGH]),
    .flagQ   (highFlag)
  );

  // identifier and shared bytes; identifier ignores vme writes
  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++) begin : g_byte
      localparam vgc_idx_t IDX = vgc_idx_t'(gi + 2);
      localparam vgc_byte_t RV = (gi == 0) ? `VGC_RST_BOARD_IDENTIFIER :
                                 (gi == 1) ? `VGC_RST_SHARED0 : `VGC_RST_SHARED;
      assign locWrByte[gi] = locSel && locWrite && locHit && !locBaseHit && (locIdx == IDX);
      assign vmeWrByte[gi] = vmeHit && vmeWrite && (vmeIdx == IDX) && (gi != 0);
      vgc_byte_reg #(
        .RESET_VAL (RV)
      ) u_byte (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .locWr   (locWrByte[gi]),
        .locData (locWdata),
        .vmeWr   (vmeWrByte[gi]),
        .vmeData (vmeWdata),
        .valueQ  (bytesQ[gi])
      );
    end
  endgenerate

  // global control/status image, bits 2 and 3 fixed at zero
  assign global1 = {state_q.rh, state_q.strap, state_q.sysfail_inhibit, state_q.fail,
                    2'b00, highFlag, lowFlag};

  // read mux shared by both ports
  function automatic vgc_byte_t readReg(input vgc_idx_t idx);
    vgc_byte_t r;
    r = 8'h00;
    if (idx == `VGC_IDX_GLOBAL1) begin
      r = global1;
    end else if (idx >= `VGC_IDX_BOARD_IDENTIFIER) begin
      r = bytesQ[idx - `VGC_IDX_BOARD_IDENTIFIER];
    end
    return r;
  endfunction

  // next state: shared control bits, mirrors, outputs and answers
  always_comb begin
    state_d = state_q;
    state_d.fail  = boardFailLine;
    state_d.strap = strapSysCon;
    if (locSel && locWrite && locBaseHit) begin
      state_d.base = locWdata[3:0];
    end
    // inhibit: local write beats a same-cycle vme write
    if (locWrG1) begin
      state_d.sysfail_inhibit = locWdata[`VGC_BIT_ISF];
    end else if (vmeWrG1) begin
      state_d.sysfail_inhibit = vmeWdata[`VGC_BIT_ISF];
    end
    // reset-and-hold: only the far side may clear it
    if (locWrG1 && locWdata[`VGC_BIT_RH]) begin
      state_d.rh = 1'b1;
    end else if (vmeWrG1) begin
      state_d.rh = vmeWdata[`VGC_BIT_RH];
    end
    state_d.sysfail = boardFailLine && !state_q.sysfail_inhibit;
    state_d.irq1 = lowFlag && lowIrqEnable && baseValid;
    state_d.irq5 = highFlag && highIrqEnable && baseValid;
    // answers one cycle after the select
    state_d.locAck = locSel;
    state_d.locRd  = 8'h00;
    if (locSel && !locWrite) begin
      if (locBaseHit) begin
        state_d.locRd = {4'h0, state_q.base};
      end else if (locHit) begin
        state_d.locRd = readReg(locIdx);
      end
    end
    state_d.vmeAck = vmeHit;
    state_d.vmeRd  = 8'h00;
    if (vmeHit && !vmeWrite) begin
      state_d.vmeRd = readReg(vmeIdx);
    end
  end

  // single state register of the bank
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= '0;
      state_q.base <= `VGC_RST_BASE;
    end else begin
      state_q <= state_d;
    end
  end

  assign locRdata       = state_q.locRd;
  assign locAck         = state_q.locAck;
  assign vmeRdata       = state_q.vmeRd;
  assign vmeAck         = state_q.vmeAck;
  assign irqLevel1Req   = state_q.irq1;
  assign irqLevel5Req   = state_q.irq5;
  assign sysfailAssert  = state_q.sysfail;
  assign boardResetHold = state_q.rh;
  assign baseNibble     = state_q.base;

  // interrupt requests follow flag, enable and mapping
  chk_low_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (lowFlag && lowIrqEnable && baseValid) |=> irqLevel1Req)
    else $error("level 1 request missing");
  chk_high_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (highFlag && highIrqEnable && baseValid) |=> irqLevel5Req)
    else $error("level 5 request missing");
  chk_unmapped_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !baseValid |=> !irqLevel1Req && !irqLevel5Req && !vmeAck)
    else $error("unmapped set responded");
  // status mirrors and the sysfail contribution
  chk_fail_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (locSel && !locWrite && !locBaseHit && locHit && locIdx == `VGC_IDX_GLOBAL1
     && $past(rst_n)) |=> locRdata[`VGC_BIT_FAIL] == $past(boardFailLine, 2))
    else $error("fail mirror wrong");
  chk_inhibit_fail: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q.sysfail_inhibit |=> !sysfailAssert)
    else $error("sysfail driven while inhibited");
  chk_sysfail_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (boardFailLine && !state_q.sysfail_inhibit) |=> sysfailAssert)
    else $error("sysfail contribution missing");
  chk_fail_indep: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 global1[`VGC_BIT_FAIL] == $past(boardFailLine))
    else $error("fail status not following line");
  chk_rh_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (vmeWrG1 && vmeWdata[`VGC_BIT_RH]) |=> boardResetHold)
    else $error("reset hold not taken");
  chk_rh_self: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (boardResetHold && !vmeWrG1) |=> boardResetHold)
    else $error("reset hold dropped without far write");
  chk_id_readonly: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (vmeHit && vmeWrite && vmeIdx == `VGC_IDX_BOARD_IDENTIFIER && !locWrByte[0])
    |=> $stable(bytesQ[0]))
    else $error("identifier changed by vme");
  chk_id_local: assert property (@(posedge ref_clk) disable iff (!rst_n)
    locWrByte[0] |=> bytesQ[0] == $past(locWdata))
    else $error("identifier local write lost");
  chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    global1[3:2] == 2'b00)
    else $error("reserved bits not zero");
  chk_vme_index: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (vmeSel && vmeAddr[0] && vmeAddr[3:1] != 3'h0 && baseValid
     && vmeAddr[15:4] == {8'h00, state_q.base}) |=> vmeAck)
    else $error("mapped vme access not answered");

  // main scenarios: flag interrupt, hold cycle, collisions, blocked id, inhibit
  cov_low_irq: cover property (@(posedge ref_clk) disable iff (!rst_n)
    (vmeWrG1 && vmeWdata[0]) ##[1:4] irqLevel1Req);
  cov_rh_cycle: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(boardResetHold) ##[1:600] $fell(boardResetHold));
  cov_same_cycle: cover property (@(posedge ref_clk) disable iff (!rst_n)
    vmeWrG1 && locWrG1);
  cov_id_blocked: cover property (@(posedge ref_clk) disable iff (!rst_n)
    vmeHit && vmeWrite && vmeIdx == `VGC_IDX_BOARD_IDENTIFIER);
  cov_inhibited_fail: cover property (@(posedge ref_clk) disable iff (!rst_n)
    boardFailLine && state_q.sysfail_inhibit);
endmodule
`default_nettype wire

/* File: testbench/vgc_vme_master.sv */
// vme master model on the short i/o port of the register bank
// assumes ref_clk from the bench; strobes launched on falling edges
`timescale 1ns/1ps
`default_nettype none
module vgc_vme_master (
  input  wire logic               ref_clk,
  output logic                    vmeSel,
  output logic                    vmeWrite,
  output vgc_pkg::vgc_vaddr_t     vmeAddr,
  output vgc_pkg::vgc_byte_t      vmeWdata,
  input  wire vgc_pkg::vgc_byte_t vmeRdata,
  input  wire logic               vmeAck
);
  import vgc_pkg::*;
  // idle bus at time zero
  initial begin
    vmeSel = 1'b0;
    vmeWrite = 1'b0;
    vmeAddr = 16'h0000;
    vmeWdata = 8'h00;
  end
  // one strobe cycle, answer taken one cycle later
  task automatic access(input logic wr, input vgc_vaddr_t a, input vgc_byte_t wd,
                        output vgc_byte_t rd, output logic ack);
    @(negedge ref_clk);
    vmeSel = 1'b1;
    vmeWrite = wr;
    vmeAddr = a;
    vmeWdata = wd;
    @(negedge ref_clk);
    ack = vmeAck;
    rd = vmeRdata;
    vmeSel = 1'b0;
    // released lines show the inverse of the last value
    vmeWrite = ~wr;
    vmeAddr = ~a;
    vmeWdata = ~wd;
  endtask
endmodule
`default_nettype wire

/* File: testbench/vgc_csr_bank_tb_top.sv */
// self-checking bench for the global register bank
// assumes vgc_vme_master on the vme port and vgc_cfg.svh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "vgc_cfg.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %0t got %h exp %h", $time, (g), (e)); end end
module vgc_csr_bank_tb_top;
  import vgc_pkg::*;
  logic       ref_clk;
  logic       rst_n;
  logic       locSel;
  logic       locWrite;
  vgc_laddr_t locAddr;
  vgc_byte_t  locWdata;
  vgc_byte_t  locRdata;
  logic       locAck;
  logic       vmeSel;
  logic       vmeWrite;
  vgc_vaddr_t vmeAddr;
  vgc_byte_t  vmeWdata;
  vgc_byte_t  vmeRdata;
  logic       vmeAck;
  logic       boardFailLine;
  logic       strapSysCon;
  logic       lowIrqEnable;
  logic       highIrqEnable;
  logic       irqLevel1Req;
  logic       irqLevel5Req;
  logic       sysfailAssert;
  logic       boardResetHold;
  logic [3:0] baseNibble;
  logic [3:0] base;
  vgc_byte_t  mdl [8];
  vgc_vaddr_t un [4];
  vgc_byte_t  d;
  vgc_byte_t  rd;
  int         errors;
  int         n_tests;
  int         k;
  int         seed;
  vgc_csr_bank i_vgc_csr_bank (
    .ref_clk(ref_clk), .rst_n(rst_n), .locSel(locSel), .locWrite(locWrite),
    .locAddr(locAddr), .locWdata(locWdata), .locRdata(locRdata), .locAck(locAck),
    .vmeSel(vmeSel), .vmeWrite(vmeWrite), .vmeAddr(vmeAddr), .vmeWdata(vmeWdata),
    .vmeRdata(vmeRdata), .vmeAck(vmeAck), .boardFailLine(boardFailLine),
    .strapSysCon(strapSysCon), .lowIrqEnable(lowIrqEnable),
    .highIrqEnable(highIrqEnable), .irqLevel1Req(irqLevel1Req),
    .irqLevel5Req(irqLevel5Req), .sysfailAssert(sysfailAssert),
    .boardResetHold(boardResetHold), .baseNibble(baseNibble));
  vgc_vme_master i_vgc_vme_master (
    .ref_clk(ref_clk), .vmeSel(vmeSel), .vmeWrite(vmeWrite), .vmeAddr(vmeAddr),
    .vmeWdata(vmeWdata), .vmeRdata(vmeRdata), .vmeAck(vmeAck));
  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // register addresses by index: 1 global, 2 id, 3..7 shared
  function automatic vgc_laddr_t la(input int i);
    return `VGC_LOC_GLOBAL1 + 32'(2 * (i - 1));
  endfunction
  function automatic vgc_vaddr_t va(input int i);
    return {`VGC_VME_HIGH_BYTE, base, 3'(i), 1'b1};
  endfunction
  // local access: strobe one cycle, answer in the next
  task automatic loc(input logic wr, input vgc_laddr_t a, input vgc_byte_t wd);
    @(negedge ref_clk);
    locSel = 1'b1;
    locWrite = wr;
    locAddr = a;
    locWdata = wd;
    @(negedge ref_clk);
    `CHK(locAck, 1'b1)
    rd = locRdata;
    locSel = 1'b0;
    locWrite = ~wr;
    locAddr = ~a;
    locWdata = ~wd;
  endtask
  task automatic lr(input vgc_laddr_t a, input vgc_byte_t e);
    loc(1'b0, a, 8'h00);
    `CHK(rd, e)
  endtask
  // vme access through the master model, ack against expected decode
  task automatic vx(input logic wr, input vgc_vaddr_t a, input vgc_byte_t wd,
                    input logic ea);
    logic ack;
    i_vgc_vme_master.access(wr, a, wd, rd, ack);
    `CHK(ack, ea)
  endtask
  task automatic vr(input vgc_vaddr_t a, input vgc_byte_t e);
    vx(1'b0, a, 8'h00, 1'b1);
    `CHK(rd, e)
  endtask
  // system reset, then every register against its reset value
  task automatic sys_reset();
    rst_n = 1'b0;
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    `CHK(baseNibble, `VGC_RST_BASE)
    for (int i = 1; i < 8; i++) begin
      lr(la(i), (i == 3) ? `VGC_RST_SHARED0 : 8'h00);
    end
    lr(`VGC_LOC_BASE_CFG, 8'h0F);
    base = 4'hF;
  endtask
  // close the run with the verdict
  task automatic conclude();
    if (errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {rst_n, locSel, locWrite, boardFailLine, strapSysCon} = 5'b0;
    {lowIrqEnable, highIrqEnable} = 2'b11;
    locAddr = 32'h0000_0000;
    locWdata = 8'h00;
    errors = 0;
    n_tests = 0;
    seed = $urandom(80829);
    sys_reset();
    // unmapped set: no answer, no flag
    vx(1'b1, va(1), 8'h03, 1'b0);
    lr(la(1), 8'h00);
    base = 4'($urandom_range(14, 0));
    loc(1'b1, `VGC_LOC_BASE_CFG, {4'h0, base});
    `CHK(baseNibble, base)
    vx(1'b1, va(1), 8'h01, 1'b1);
    lr(la(1), 8'h01);
    `CHK({irqLevel1Req, irqLevel5Req}, 2'b10)
    vx(1'b1, va(1), 8'h02, 1'b1);
    vx(1'b1, va(1), 8'h00, 1'b1);
    lr(la(1), 8'h03);
    `CHK(irqLevel5Req, 1'b1)
    loc(1'b1, la(1), 8'h01);
    lr(la(1), 8'h02);
    `CHK({irqLevel1Req, irqLevel5Req}, 2'b01)
    {lowIrqEnable, highIrqEnable} = 2'b00;
    vx(1'b1, va(1), 8'h01, 1'b1);
    lr(la(1), 8'h03);
    `CHK({irqLevel1Req, irqLevel5Req}, 2'b00)
    {lowIrqEnable, highIrqEnable} = 2'b11;
    loc(1'b1, la(1), 8'h03);
    `CHK(irqLevel5Req, 1'b1)
    loc(1'b1, la(1), 8'h03);
    lr(la(1), 8'h00);
    `CHK({irqLevel1Req, irqLevel5Req}, 2'b00)
    // set and clear in the same cycle
    fork
      vx(1'b1, va(1), 8'h01, 1'b1);
      loc(1'b1, la(1), 8'h01);
    join
    lr(la(1), 8'h01);
    loc(1'b1, la(1), 8'h01);
    // status mirrors and sysfail inhibit
    boardFailLine = 1'b1;
    strapSysCon = 1'b1;
    lr(la(1), 8'h50);
    `CHK(sysfailAssert, 1'b1)
    vx(1'b1, va(1), 8'h20, 1'b1);
    lr(la(1), 8'h70);
    `CHK(sysfailAssert, 1'b0)
    loc(1'b1, la(1), 8'h0C);
    lr(la(1), 8'h50);
    {boardFailLine, strapSysCon} = 2'b00;
    lr(la(1), 8'h00);
    // self-set reset-and-hold, cleared only by the remote master
    loc(1'b1, la(1), 8'h80);
    loc(1'b1, la(1), 8'h00);
    lr(la(1), 8'h80);
    `CHK(boardResetHold, 1'b1)
    repeat (`VGC_RH_MIN_CYC) @(negedge ref_clk);
    vx(1'b1, va(1), 8'h00, 1'b1);
    lr(la(1), 8'h00);
    `CHK(boardResetHold, 1'b0)
    // board identifier: read only from the vme side
    d = 8'($urandom);
    loc(1'b1, la(2), d);
    vx(1'b1, va(2), ~d, 1'b1);
    vr(va(2), d);
    // random shared-byte traffic, read back through the other port
    mdl[3] = `VGC_RST_SHARED0;
    repeat (40) begin
      k = $urandom_range(7, 3);
      d = 8'($urandom);
      mdl[k] = d;
      if ($urandom_range(1, 0) == 0) begin
        loc(1'b1, la(k), d);
        vr(va(k), d);
      end else begin
        vx(1'b1, va(k), d, 1'b1);
        lr(la(k), d);
      end
    end
    // unanswered vme accesses (wrong high byte, index 0, even byte, next block) and an unmapped local address
    un[0] = {8'h01, base, 4'h7};
    un[1] = {8'h00, base, 4'h1};
    un[2] = {8'h00, base, 4'h6};
    un[3] = {8'h00, base + 4'h1, 4'h7};
    for (int i = 0; i < 4; i++) begin
      vx(1'b1, un[i], 8'hA5, 1'b0);
    end
    vr(va(3), mdl[3]);
    lr(32'hFFFE2031, 8'h00);
    // second reset at the end of the run, before the verdict
    sys_reset();
    conclude();
  end
endmodule
`default_nettype wire
